// file: logic/reg_obj.sv
// Purpose: Register-object command interpreter for parameter access.
// Assumes: Scanner requests and drive services use valid/ready pairs.
// Notes:   APB slave holds events, mask, control and per-instance flags.
// Overview of operation
// R1: Nine parameter instances; class attribute 2 reports nine.
// R2: Only single-attribute get and set are accepted; other services answer a service error.
// R3: Input instances read only; output instances read and write.
// R4: Get starts read, min, max, default, scale, attribute or NVM read.
// R5: Set writes on 2, volatile write on 3, invalid elsewhere.
// R6: Attribute 1 is the error flag of the last data access, reset 0.
// R7: Attribute 2 reads 00 for input, 01 for output instances.
// R8: Attribute 3 reads 0060 hex, the 96-bit channel length.
// R9: Data attribute requests carry a channel; answers return the same form.
// R10: Channel is index, value, subindex, reserved, two address pairs.
// R11: Invalid set starts nothing, answers error, sets the error flag.
`timescale 1ns/1ps
`default_nettype none
module reg_obj (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic [7:0]    paddr,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   output logic               irq,
   input  wire logic          req_valid,
   output logic               req_ready,
   input  wire logic [7:0]    req_service,
   input  wire logic [7:0]    req_instance,
   input  wire logic [7:0]    req_attribute,
   input  wire logic [95:0]   req_data,
   output logic               rsp_valid,
   input  wire logic          rsp_ready,
   output logic      [7:0]    rsp_status,
   output logic      [95:0]   rsp_data,
   output logic               svc_valid,
   input  wire logic          svc_ready,
   output logic      [3:0]    svc_code,
   output logic      [15:0]   svc_index,
   output logic      [31:0]   svc_value,
   output logic      [7:0]    svc_subindex,
   output logic      [7:0]    svc_subaddr1,
   output logic      [7:0]    svc_subchan1,
   output logic      [7:0]    svc_subaddr2,
   output logic      [7:0]    svc_subchan2,
   input  wire logic          svc_done,
   input  wire logic          svc_fail,
   input  wire logic [31:0]   svc_rd_value
);
   typedef enum logic [5:0] {
      ST_IDLE   = 6'b000001,
      ST_DECODE = 6'b000010,
      ST_ISSUE  = 6'b000100,
      ST_WAIT   = 6'b001000,
      ST_READ   = 6'b010000,
      ST_RESP   = 6'b100000
   } state_t;

   state_t                     state;
   logic [7:0]                 svc_q;
   logic [7:0]                 inst_q;
   logic [7:0]                 attr_q;
   logic [95:0]                chan_q;
   logic                       fail_q;
   logic                       load_q;
   logic [9:1]                 bad;
   logic [reg_obj_pkg::EV_W-1:0] status;
   logic [reg_obj_pkg::EV_W-1:0] mask;
   logic [reg_obj_pkg::EV_W-1:0] ev;
   logic [31:0]                ctrl;
   logic                       map_ok;
   logic [3:0]                 map_code;
   logic                       map_dir;
   logic                       is_get;
   logic                       is_set;
   logic                       inst_ok;
   logic                       invalid_set;
   logic                       mem_we;
   logic [95:0]                mem_wdata;
   logic [95:0]                mem_rdata;
   logic                       acc_done;
   logic                       rd_status;

   // Request decode helpers
   assign is_get = (svc_q == reg_obj_pkg::GET_SINGLE);
   assign is_set = (svc_q == reg_obj_pkg::SET_SINGLE);
   assign inst_ok = (inst_q != reg_obj_pkg::INST_CLASS)
                  && (inst_q <= reg_obj_pkg::NUM_INST); // [R1]
   assign invalid_set = (state == ST_DECODE) && is_set && inst_ok
                      && (attr_q == reg_obj_pkg::ATTR_DATA)
                      && !map_ok; // [R11]

   svc_map u_map (
      .inst    (inst_q[3:0]),
      .is_set  (is_set),
      .ok      (map_ok),
      .code    (map_code),
      .dir_out (map_dir)
   );

   // Result channel: same layout as the request, value from the drive on a get
   always_comb begin
      mem_wdata = chan_q;
      mem_wdata[reg_obj_pkg::RSV_L +: 8] = 8'h00;
      if (!is_set) mem_wdata[reg_obj_pkg::VAL_L +: 32] = svc_rd_value; // [R9]
   end
   assign mem_we = (state == ST_WAIT) && svc_done;

   chan_mem u_mem (
      .pclk  (pclk),
      .we    (mem_we),
      .rd_en (state == ST_READ),
      .addr  (inst_q[3:0]),
      .wdata (mem_wdata),
      .rdata (mem_rdata)
   );

   // Accept requests only when idle and enabled
   assign req_ready = (state == ST_IDLE) && ctrl[reg_obj_pkg::CTRL_EN];
   assign rsp_valid = (state == ST_RESP) && !load_q; // Reply loads first
   assign svc_valid = (state == ST_ISSUE);

   // Main sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE:
               if (req_valid && req_ready) state <= ST_DECODE;
            ST_DECODE:
               if (is_set || is_get) begin // [R2]
                  if (inst_ok && attr_q == reg_obj_pkg::ATTR_DATA
                      && map_ok) state <= ST_ISSUE; // [R3]
                  else state <= ST_RESP;
               end else begin
                  state <= ST_RESP;
               end
            ST_ISSUE:
               if (svc_ready) state <= ST_WAIT;
            ST_WAIT:
               if (svc_done) state <= ST_READ;
            ST_READ:
               state <= ST_RESP;
            ST_RESP:
               if (rsp_valid && rsp_ready) state <= ST_IDLE;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Request capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         svc_q <= 8'h00;
         inst_q <= 8'h00;
         attr_q <= 8'h00;
         chan_q <= '0;
      end else if (req_valid && req_ready) begin
         svc_q <= req_service;
         inst_q <= req_instance;
         attr_q <= req_attribute;
         chan_q <= req_data;
      end
   end

   // Drive service fields unpacked from the channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         svc_code <= reg_obj_pkg::DRV_READ;
         svc_index <= 16'h0000;
         svc_value <= 32'h0000_0000;
         svc_subindex <= 8'h00;
         svc_subaddr1 <= 8'h00;
         svc_subchan1 <= 8'h00;
         svc_subaddr2 <= 8'h00;
         svc_subchan2 <= 8'h00;
      end else if (state == ST_DECODE) begin
         svc_code <= map_code; // [R4] [R5]
         svc_index <= chan_q[reg_obj_pkg::IDX_L +: 16]; // [R10]
         svc_value <= chan_q[reg_obj_pkg::VAL_L +: 32];
         svc_subindex <= chan_q[reg_obj_pkg::SIX_L +: 8];
         svc_subaddr1 <= chan_q[reg_obj_pkg::SA1_L +: 8];
         svc_subchan1 <= chan_q[reg_obj_pkg::SC1_L +: 8];
         svc_subaddr2 <= chan_q[reg_obj_pkg::SA2_L +: 8];
         svc_subchan2 <= chan_q[reg_obj_pkg::SC2_L +: 8];
      end
   end

   // Drive outcome and delayed memory load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fail_q <= 1'b0;
         load_q <= 1'b0;
      end else begin
         if (mem_we) fail_q <= svc_fail;
         load_q <= (state == ST_READ);
      end
   end

   // Response data and status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_status <= reg_obj_pkg::RSP_OK;
         rsp_data <= '0;
      end else if (state == ST_DECODE) begin
         rsp_data <= '0;
         rsp_status <= reg_obj_pkg::RSP_OK;
         if (!is_get && !is_set) begin
            rsp_status <= reg_obj_pkg::RSP_ERR_SVC; // [R2]
         end else if (inst_q == reg_obj_pkg::INST_CLASS) begin
            if (is_get && attr_q == reg_obj_pkg::ATTR_MAXI)
               rsp_data[7:0] <= reg_obj_pkg::NUM_INST; // [R1]
            else if (is_set)
               rsp_status <= reg_obj_pkg::RSP_ERR_RO;
            else
               rsp_status <= reg_obj_pkg::RSP_ERR_ATTR;
         end else if (!inst_ok) begin
            rsp_status <= reg_obj_pkg::RSP_ERR_INST;
         end else if (attr_q == reg_obj_pkg::ATTR_DATA) begin
            if (!map_ok) rsp_status <= reg_obj_pkg::RSP_ERR_RO; // [R11]
         end else if (is_set && attr_q >= reg_obj_pkg::ATTR_BAD
                      && attr_q <= reg_obj_pkg::ATTR_SIZE) begin
            rsp_status <= reg_obj_pkg::RSP_ERR_RO;
         end else if (attr_q == reg_obj_pkg::ATTR_BAD) begin
            rsp_data[0] <= bad[inst_q[3:0]]; // [R6]
         end else if (attr_q == reg_obj_pkg::ATTR_DIR) begin
            rsp_data[7:0] <= map_dir ? reg_obj_pkg::DIR_OUT
                                     : reg_obj_pkg::DIR_IN; // [R7]
         end else if (attr_q == reg_obj_pkg::ATTR_SIZE) begin
            rsp_data[15:0] <= reg_obj_pkg::SIZE_BITS; // [R8]
         end else begin
            rsp_status <= reg_obj_pkg::RSP_ERR_ATTR;
         end
      end else if (load_q) begin
         rsp_data <= mem_rdata; // [R9]
         rsp_status <= fail_q ? reg_obj_pkg::RSP_ERR_DRV
                              : reg_obj_pkg::RSP_OK;
      end
   end

   // Per-instance error flags of the data attribute
   genvar gi;
   generate
      for (gi = 1; gi <= 9; gi++) begin : g_bad
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) bad[gi] <= 1'b0; // [R6]
            else if (inst_q[3:0] == 4'(gi)) begin
               if (invalid_set) bad[gi] <= 1'b1; // [R11]
               else if (mem_we) bad[gi] <= svc_fail; // [R6]
            end
         end
      end
   endgenerate

   // Block events
   always_comb begin
      ev = '0;
      ev[reg_obj_pkg::EV_DONE] = rsp_valid && rsp_ready;
      ev[reg_obj_pkg::EV_FAIL] = mem_we && svc_fail;
      ev[reg_obj_pkg::EV_INVAL] = invalid_set;
   end

   // APB: one wait state, answer on the second access cycle
   assign acc_done = psel && penable && pready;
   assign rd_status = acc_done && !pwrite
                    && (paddr == reg_obj_pkg::A_STATUS);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pready <= 1'b0;
      else pready <= psel && penable && !pready;
   end

   // Read data and error answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         case (paddr)
            reg_obj_pkg::A_STATUS: if (!pwrite) prdata[2:0] <= status;
            reg_obj_pkg::A_MASK:   if (!pwrite) prdata[2:0] <= mask;
            reg_obj_pkg::A_CTRL:   if (!pwrite) prdata <= ctrl;
            reg_obj_pkg::A_BAD:    if (!pwrite) prdata[9:1] <= bad;
            reg_obj_pkg::A_STATE:  if (!pwrite) prdata[5:0] <= state;
            default:               pslverr <= 1'b1;
         endcase
      end
   end

   // Sticky status, cleared by read; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) status <= '0;
      else status <= (status & {reg_obj_pkg::EV_W{!rd_status}}) | ev;
   end

   // Mask and control writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask <= '0;
         ctrl <= reg_obj_pkg::CTRL_RST;
      end else if (acc_done && pwrite) begin
         if (paddr == reg_obj_pkg::A_MASK) mask <= pwdata[2:0];
         if (paddr == reg_obj_pkg::A_CTRL)
            ctrl <= {31'h0000_0000, pwdata[reg_obj_pkg::CTRL_EN]};
      end
   end

   assign irq = |(status & mask);

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence drv_done_s;
      (state == ST_WAIT) && svc_done && !svc_fail && !is_set;
   endsequence
   sequence answer_s;
      (state == ST_READ) ##1 (state == ST_RESP);
   endsequence

   max_inst_a: assert property ( // [R1]
      (state == ST_DECODE) && is_get && inst_q == reg_obj_pkg::INST_CLASS
      && attr_q == reg_obj_pkg::ATTR_MAXI
      |=> rsp_valid && rsp_data[7:0] == 8'h09)
      else $error("class instance count wrong");
   svc_only_a: assert property ( // [R2]
      (state == ST_DECODE) && !is_get && !is_set
      |=> rsp_valid && rsp_status == reg_obj_pkg::RSP_ERR_SVC)
      else $error("unsupported service accepted");
   input_ro_a: assert property ( // [R3]
      svc_valid && (svc_code == reg_obj_pkg::DRV_WRITE
                    || svc_code == reg_obj_pkg::DRV_WRVOL)
      |-> is_set && (inst_q == 8'h02 || inst_q == 8'h03))
      else $error("write issued to an input instance");
   get_map_a: assert property ( // [R4]
      svc_valid && is_get |-> (inst_q == 8'h09) == (svc_code == 4'h8)
      && (inst_q == 8'h07) == (svc_code == 4'h6)
      && (inst_q <= 8'h03) == (svc_code == 4'h0))
      else $error("get mapped to wrong drive service");
   set_map_a: assert property ( // [R5]
      svc_valid && is_set |-> (inst_q == 8'h02 && svc_code == 4'h1)
      || (inst_q == 8'h03 && svc_code == 4'h2))
      else $error("set mapped to wrong drive service");
   bad_flag_a: assert property ( // [R6]
      (state == ST_WAIT) && svc_done
      |=> bad[inst_q[3:0]] == $past(svc_fail))
      else $error("error flag does not follow the access");
   dir_attr_a: assert property ( // [R7]
      (state == ST_DECODE) && is_get && inst_ok && attr_q == 8'h02
      |=> rsp_data[7:0] == ((inst_q == 8'h02 || inst_q == 8'h03)
                            ? 8'h01 : 8'h00))
      else $error("direction attribute wrong");
   size_attr_a: assert property ( // [R8]
      (state == ST_DECODE) && is_get && inst_ok && attr_q == 8'h03
      |=> rsp_valid && rsp_data[15:0] == 16'h0060)
      else $error("size attribute wrong");
   chan_reply_a: assert property ( // [R9]
      drv_done_s |-> ##1 answer_s ##1 rsp_valid
      && rsp_data[79:48] == $past(svc_rd_value, 3)
      && rsp_data[95:80] == svc_index)
      else $error("reply channel not in request form");
   chan_pack_a: assert property ( // [R10]
      (state == ST_DECODE) && (is_get || is_set) && inst_ok && map_ok
      && attr_q == 8'h04
      |=> svc_valid && svc_index == chan_q[95:80]
      && svc_value == chan_q[79:48] && svc_subchan2 == chan_q[7:0])
      else $error("channel fields unpacked in wrong order");
   invalid_set_a: assert property ( // [R11]
      invalid_set |=> rsp_valid && !svc_valid && bad[inst_q[3:0]]
      && rsp_status == reg_obj_pkg::RSP_ERR_RO)
      else $error("invalid set not refused");
endmodule : reg_obj
`default_nettype wire

// file: logic/reg_obj_pkg.sv
// Purpose: Shared constants of the register-object parameter channel.
// Assumes: One 100 MHz clock, APB register access.
// Notes:   Channel fields are packed most significant first.
package reg_obj_pkg;
   // Request services and attribute numbers
   localparam logic [7:0] GET_SINGLE = 8'h0E;
   localparam logic [7:0] SET_SINGLE = 8'h10;
   localparam logic [7:0] NUM_INST   = 8'h09;
   localparam logic [7:0] ATTR_BAD   = 8'h01;
   localparam logic [7:0] ATTR_DIR   = 8'h02;
   localparam logic [7:0] ATTR_SIZE  = 8'h03;
   localparam logic [7:0] ATTR_DATA  = 8'h04;
   localparam logic [7:0] ATTR_MAXI  = 8'h02;
   localparam logic [7:0] INST_CLASS = 8'h00;
   localparam logic [7:0] INST_WR    = 8'h02;
   localparam logic [7:0] INST_WRV   = 8'h03;
   localparam logic [15:0] SIZE_BITS = 16'h0060;
   localparam logic [7:0] DIR_IN     = 8'h00;
   localparam logic [7:0] DIR_OUT    = 8'h01;
   // Parameter channel layout: index, value, subindex, reserved, 2 x pairs
   localparam int CH_W = 96;
   localparam int IDX_L = 80;
   localparam int VAL_L = 48;
   localparam int SIX_L = 40;
   localparam int RSV_L = 32;
   localparam int SA1_L = 24;
   localparam int SC1_L = 16;
   localparam int SA2_L = 8;
   localparam int SC2_L = 0;
   // Drive parameter service codes
   localparam logic [3:0] DRV_READ = 4'h0;
   localparam logic [3:0] DRV_WRITE = 4'h1;
   localparam logic [3:0] DRV_WRVOL = 4'h2;
   localparam logic [3:0] DRV_MIN = 4'h3;
   localparam logic [3:0] DRV_MAX = 4'h4;
   localparam logic [3:0] DRV_DEF = 4'h5;
   localparam logic [3:0] DRV_SCALE_FACTOR_READ = 4'h6;
   localparam logic [3:0] DRV_ATTR = 4'h7;
   localparam logic [3:0] DRV_NVM = 4'h8;
   // Response status codes
   localparam logic [7:0] RSP_OK = 8'h00;
   localparam logic [7:0] RSP_ERR_SVC = 8'h08;
   localparam logic [7:0] RSP_ERR_RO = 8'h0E;
   localparam logic [7:0] RSP_ERR_ATTR = 8'h14;
   localparam logic [7:0] RSP_ERR_INST = 8'h16;
   localparam logic [7:0] RSP_ERR_DRV = 8'h1F;
   // APB map, event bits and reset values
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_MASK = 8'h04;
   localparam logic [7:0] A_CTRL = 8'h08;
   localparam logic [7:0] A_BAD = 8'h0C;
   localparam logic [7:0] A_STATE = 8'h10;
   localparam int EV_DONE = 0;
   localparam int EV_FAIL = 1;
   localparam int EV_INVAL = 2;
   localparam int EV_W = 3;
   localparam int CTRL_EN = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam int MEM_AW = 4;
endpackage : reg_obj_pkg

// file: logic/svc_map.sv
// Purpose: Maps instance and request direction to a drive service.
// Assumes: Instance already checked to lie in 1..9.
// Notes:   Purely combinational lookup.
`timescale 1ns/1ps
`default_nettype none
module svc_map (
   input  wire logic [3:0] inst,
   input  wire logic       is_set,
   output logic            ok,
   output logic [3:0]      code,
   output logic            dir_out
);
   // Service table per instance
   always_comb begin
      ok = 1'b1;
      code = reg_obj_pkg::DRV_READ;
      dir_out = 1'b0;
      case (inst)
         4'h2: begin
            dir_out = 1'b1;
            code = is_set ? reg_obj_pkg::DRV_WRITE : reg_obj_pkg::DRV_READ;
         end
         4'h3: begin
            dir_out = 1'b1;
            code = is_set ? reg_obj_pkg::DRV_WRVOL : reg_obj_pkg::DRV_READ;
         end
         4'h4: code = reg_obj_pkg::DRV_MIN;
         4'h5: code = reg_obj_pkg::DRV_MAX;
         4'h6: code = reg_obj_pkg::DRV_DEF;
         4'h7: code = reg_obj_pkg::DRV_SCALE_FACTOR_READ;
         4'h8: code = reg_obj_pkg::DRV_ATTR;
         4'h9: code = reg_obj_pkg::DRV_NVM;
         default: code = reg_obj_pkg::DRV_READ;
      endcase
      // Input instances refuse writes
      if (is_set && !dir_out) ok = 1'b0;
   end
endmodule : svc_map
`default_nettype wire

// file: logic/chan_mem.sv
// Purpose: Holds the last parameter channel of each instance.
// Assumes: One write or one read per cycle.
// Notes:   Read data come from a register, one cycle after rd_en.
`timescale 1ns/1ps
`default_nettype none
module chan_mem (
   input  wire logic                            pclk,
   input  wire logic                            we,
   input  wire logic                            rd_en,
   input  wire logic [reg_obj_pkg::MEM_AW-1:0]  addr,
   input  wire logic [reg_obj_pkg::CH_W-1:0]    wdata,
   output logic      [reg_obj_pkg::CH_W-1:0]    rdata
);
   logic [reg_obj_pkg::CH_W-1:0] mem [0:(1<<reg_obj_pkg::MEM_AW)-1];
   // Write port and registered read port
   always_ff @(posedge pclk) begin
      if (we) mem[addr] <= wdata;
      if (rd_en) rdata <= mem[addr];
   end
endmodule : chan_mem
`default_nettype wire

// file: testbench/drive_model.sv
// Purpose: Drive parameter store that answers service requests.
// Assumes: lag gives extra wait cycles before done, 0 answers promptly.
// Notes:   Index FFFF makes the drive report a failure.
`timescale 1ns/1ps
`default_nettype none
module drive_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        svc_valid,
   input  wire logic [3:0]  svc_code,
   input  wire logic [15:0] svc_index,
   input  wire logic [3:0]  lag,
   output logic             svc_ready,
   output logic             svc_done,
   output logic             svc_fail,
   output logic      [31:0] svc_rd_value
);
   logic        busy;
   logic [3:0]  cnt;
   logic [19:0] held;
   // Ready only while no service is in progress
   assign svc_ready = presetn & ~busy;
   // Latch the request, wait, then pulse done with a derived value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         held <= 20'h0;
         svc_done <= 1'b0;
         svc_fail <= 1'b0;
         svc_rd_value <= 32'h0;
      end else begin
         svc_done <= 1'b0;
         svc_fail <= 1'b0;
         svc_rd_value <= ~svc_rd_value; // Not valid outside done
         if (svc_valid && svc_ready) begin
            busy <= 1'b1;
            cnt <= lag;
            held <= {svc_index, svc_code};
         end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else if (busy) begin
            busy <= 1'b0;
            svc_done <= 1'b1;
            svc_fail <= (held[19:4] == 16'hFFFF);
            svc_rd_value <= {held[19:4], 12'h000, held[3:0]};
         end
      end
   end
endmodule : drive_model
`default_nettype wire

// file: testbench/test_reg_obj.sv
// Purpose: Self-checking bench of the register-object interpreter.
// Assumes: Scanner side driven here, drive side by drive_model.
// Notes:   Responses are always accepted at once.
`timescale 1ns/1ps
`default_nettype none
module test_reg_obj;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00, req_service = 8'h00, req_instance = 8'h00;
   logic [7:0]  req_attribute = 8'h00, rsp_status, st, svc_subindex;
   logic [7:0]  svc_subaddr1, svc_subchan1, svc_subaddr2, svc_subchan2;
   logic [31:0] pwdata = 32'h0, prdata, rd, svc_value, svc_rd_value;
   logic [95:0] req_data = 96'h0, rsp_data, q, seen_ch;
   logic [15:0] svc_index;
   logic [3:0]  svc_code, seen_code, lag = 4'h0;
   logic        pready, pslverr, irq, req_valid = 0, req_ready, rsp_valid;
   logic        rsp_ready = 1, svc_valid, svc_ready, svc_done, svc_fail, err;
   int          miscompares = 0, samples_checked = 0, takes = 0;
   logic [3:0]  get_code [1:9] = '{4'h0, 4'h0, 4'h0, 4'h3, 4'h4, 4'h5,
                                   4'h6, 4'h7, 4'h8};
   // Clock
   always #5 pclk = ~pclk;
   reg_obj reg_obj_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .irq, .req_valid, .req_ready,
      .req_service, .req_instance, .req_attribute, .req_data, .rsp_valid,
      .rsp_ready, .rsp_status, .rsp_data, .svc_valid, .svc_ready, .svc_code,
      .svc_index, .svc_value, .svc_subindex, .svc_subaddr1, .svc_subchan1,
      .svc_subaddr2, .svc_subchan2, .svc_done, .svc_fail, .svc_rd_value);
   drive_model drive_model_i (.pclk, .presetn, .svc_valid, .svc_code,
      .svc_index, .lag, .svc_ready, .svc_done, .svc_fail, .svc_rd_value);
   // Record every service the drive takes
   always @(posedge pclk) if (svc_valid && svc_ready) begin
      takes <= takes + 1;
      seen_code <= svc_code;
      seen_ch <= {svc_index, svc_value, svc_subindex, 8'h00, svc_subaddr1,
                  svc_subchan1, svc_subaddr2, svc_subchan2};
   end
   task automatic chk(string nm, logic [95:0] seen, logic [95:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One APB transfer, held until pready
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   // One scanner request and its response
   task automatic scan(logic [7:0] s, i, a, logic [95:0] d);
      @(posedge pclk);
      req_valid <= 1;
      req_service <= s;
      req_instance <= i;
      req_attribute <= a;
      req_data <= d;
      do @(posedge pclk); while (req_ready !== 1'b1);
      req_valid <= 0;
      do @(posedge pclk); while (rsp_valid !== 1'b1);
      st = rsp_status;
      q = rsp_data;
   endtask : scan
   // Flag, direction and size of one instance
   task automatic attrs(int i, logic f);
      scan(reg_obj_pkg::GET_SINGLE, 8'(i), 8'h01, 96'h0);
      chk("flag", q[0], f);
      scan(reg_obj_pkg::GET_SINGLE, 8'(i), 8'h02, 96'h0);
      chk("dir", q[7:0], (i == 2 || i == 3) ? 8'h01 : 8'h00);
      scan(reg_obj_pkg::GET_SINGLE, 8'(i), 8'h03, 96'h0);
      chk("size", q[15:0], 16'h0060);
   endtask : attrs
   // Data get: service code, fields and reply layout
   task automatic get_data(int i);
      logic [95:0] d;
      int          t;
      d = {16'h2100 + 16'(i), 32'hA5A5_0000 + 32'(i), 8'h11, 8'h00,
           32'h2122_2324};
      t = takes;
      lag <= (i % 2) ? 4'h0 : 4'h6;
      scan(reg_obj_pkg::GET_SINGLE, 8'(i), 8'h04, d);
      chk("get status", st, reg_obj_pkg::RSP_OK);
      chk("get code", seen_code, get_code[i]);
      chk("get fields", seen_ch, d);
      chk("get takes", takes, t + 1);
      chk("get reply", q, {d[95:80], d[95:80], 12'h000, get_code[i],
          d[47:0]});
   endtask : get_data
   // Data set: writes on output instances, refusal elsewhere
   task automatic set_data(int i);
      logic [95:0] d;
      int          t;
      d = {16'h2200 + 16'(i), 32'h0BAD_F00D, 8'h33, 8'h00, 32'h4142_4344};
      t = takes;
      scan(reg_obj_pkg::SET_SINGLE, 8'(i), 8'h04, d);
      if (i == 2 || i == 3) begin
         chk("set code", seen_code, 4'(i - 1));
         chk("set echo", q, d);
      end else begin
         chk("inval status", st, reg_obj_pkg::RSP_ERR_RO);
         chk("inval takes", takes, t);
         scan(reg_obj_pkg::GET_SINGLE, 8'(i), 8'h01, 96'h0);
         chk("inval flag", q[0], 1'b1);
      end
   endtask : set_data
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict
   // Watchdog
   initial begin
      #50000;
      miscompares++;
      print_verdict();
   end
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      @(negedge pclk);
      chk("ready", req_ready, 1'b1);
      apb(0, reg_obj_pkg::A_CTRL, 0);
      chk("ctrl", rd, reg_obj_pkg::CTRL_RST);
      apb(0, reg_obj_pkg::A_BAD, 0);
      chk("bad reset", rd, 32'h0);
      scan(reg_obj_pkg::GET_SINGLE, 8'h00, 8'h02, 96'h0);
      chk("max inst", q[7:0], 8'h09);
      scan(reg_obj_pkg::GET_SINGLE, 8'h0A, 8'h01, 96'h0);
      chk("inst 10", st, reg_obj_pkg::RSP_ERR_INST);
      scan(8'h01, 8'h01, 8'h01, 96'h0);
      chk("service", st, reg_obj_pkg::RSP_ERR_SVC);
      for (int i = 1; i <= 9; i++) begin
         attrs(i, 1'b0);
         get_data(i);
      end
      apb(1, reg_obj_pkg::A_MASK, 32'h4);
      for (int i = 1; i <= 9; i++) set_data(i);
      @(negedge pclk);
      chk("irq on", irq, 1'b1);
      apb(0, reg_obj_pkg::A_BAD, 0);
      chk("bad map", rd, 32'h0000_03F2);
      apb(0, reg_obj_pkg::A_STATUS, 0);
      chk("status", rd[2:0], 3'b101);
      @(negedge pclk);
      chk("irq off", irq, 1'b0);
      scan(reg_obj_pkg::GET_SINGLE, 8'h02, 8'h04, {16'hFFFF, 80'h0});
      chk("fail", st, reg_obj_pkg::RSP_ERR_DRV);
      attrs(2, 1'b1);
      apb(0, reg_obj_pkg::A_BAD, 0);
      chk("fail flag", rd[2], 1'b1);
      apb(0, reg_obj_pkg::A_STATUS, 0);
      chk("fail event", rd[1], 1'b1);
      apb(1, reg_obj_pkg::A_CTRL, 0);
      @(negedge pclk);
      chk("disabled", req_ready, 1'b0);
      apb(1, reg_obj_pkg::A_CTRL, 32'h1);
      apb(0, 8'h20, 0);
      chk("unmapped", {err, rd}, {1'b1, 32'h0});
      print_verdict();
   end
endmodule : test_reg_obj
`default_nettype wire
